// [common/lpc_consts.svh]
// constants for the low-power clock-loss control block
`ifndef LPC_CONSTS_SVH
`define LPC_CONSTS_SVH
`define LPC_QC_CYCLES  13'h1000
`define LPC_SEQ_STEPS  3'h4
`define LPC_RST_SELF_CLOCK_MODE_ENABLE   1'b1
`endif

// [common/lpc_pkg.sv]
// types of the low-power clock-loss control block
package lpc_pkg;
  typedef enum logic [5:0] {
    LPC_RUN     = 6'h01,
    LPC_SEL_OSC = 6'h02,
    LPC_PLL_OFF = 6'h04,
    LPC_CORE_OFF= 6'h08,
    LPC_SYS_OFF = 6'h10,
    LPC_LOWPWR  = 6'h20
  } lpc_state_t;
endpackage

// [core/lpc_quality_check.sv]
// clock quality checker: counts good oscillator cycles after the monitor clears
`timescale 1ns/100ps
`default_nettype none
`include "lpc_consts.svh"
module lpc_quality_check #(
  parameter logic [12:0] GOOD_CYCLES = `LPC_QC_CYCLES
) (
  input  wire logic sys_clk,
  input  wire logic rstn,
  input  wire logic start,
  input  wire logic abort,
  input  wire logic hold,
  input  wire logic oscGood,
  output logic      busy,
  output logic      done
);
  logic [12:0] count;
  logic [12:0] next_count;
  logic        next_busy;
  logic        next_done;

  always_comb begin
    next_count = count;
    next_busy  = busy;
    next_done  = 1'b0;
    if (abort) begin
      next_busy  = 1'b0;
      next_count = 13'h0000;
    end else if (start) begin
      next_busy  = 1'b1;
      next_count = 13'h0000;
    end else if (busy && !hold) begin
      if (!oscGood) begin
        next_count = 13'h0000;
      end else if (count == GOOD_CYCLES - 13'h0001) begin
        next_busy  = 1'b0;
        next_done  = 1'b1;
        next_count = 13'h0000;
      end else begin
        next_count = count + 13'h0001;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      count <= 13'h0000;
      busy  <= 1'b0;
      done  <= 1'b0;
    end else begin
      count <= next_count;
      busy  <= next_busy;
      done  <= next_done;
    end
  end

  property p_done_after_good;
    @(posedge sys_clk) disable iff (!rstn)
    $rose(done) |-> $past(oscGood) && !busy;
  endproperty
  a_done_after_good: assert property (p_done_after_good) else $error("check done without good clock");
endmodule
`default_nettype wire

// [core/lpc_wb_regs.sv]
// wishbone register slave: control bits and status readback
`timescale 1ns/100ps
`default_nettype none
`include "lpc_consts.svh"
module lpc_wb_regs (
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic [7:0]  status,
  input  wire logic        flagSet,
  input  wire logic        pllSelClear,
  output logic [7:0]       ctrl,
  output logic             selfClockIrqFlag
);
  // 0x0 control, 0x4 status/flag (write 1 to bit0 clears flag)
  logic [7:0]  next_ctrl;
  logic        next_flag;
  logic        next_ack;
  logic [31:0] next_dat;
  logic        req;

  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;

  always_comb begin
    next_ctrl = ctrl;
    next_flag = selfClockIrqFlag;
    next_ack  = req;
    next_dat  = wb_dat_o;
    if (req && wb_we_i && wb_sel_i[0]) begin
      if (wb_adr_i == 4'h0) begin
        next_ctrl = wb_dat_i[7:0];
      end else if (wb_adr_i == 4'h4 && wb_dat_i[0]) begin
        next_flag = 1'b0;
      end
    end
    if (pllSelClear) begin
      next_ctrl[6] = 1'b0;
    end
    if (flagSet) begin
      next_flag = 1'b1;
    end
    if (req && !wb_we_i) begin
      unique case (wb_adr_i)
        4'h0: next_dat = {24'h000000, ctrl};
        4'h4: next_dat = {23'h000000, status, selfClockIrqFlag};
        default: next_dat = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      ctrl             <= {6'h00, `LPC_RST_SELF_CLOCK_MODE_ENABLE, 1'b0};
      selfClockIrqFlag <= 1'b0;
      wb_ack_o         <= 1'b0;
      wb_dat_o         <= 32'h00000000;
    end else begin
      ctrl             <= next_ctrl;
      selfClockIrqFlag <= next_flag;
      wb_ack_o         <= next_ack;
      wb_dat_o         <= next_dat;
    end
  end

  property p_flag_set_wins;
    @(posedge sys_clk) disable iff (!rstn)
    flagSet |=> selfClockIrqFlag;
  endproperty
  a_flag_set_wins: assert property (p_flag_set_wins) else $error("flag set lost");
endmodule
`default_nettype wire

// [core/lpc_ctrl.sv]
// low-power clock-loss control: wait and stop sequencing, self-clock handling
`timescale 1ns/100ps
`default_nettype none
`include "lpc_consts.svh"
module lpc_ctrl #(
  parameter logic [12:0] GOOD_CYCLES = `LPC_QC_CYCLES
) (
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        waitReq,
  input  wire logic        stopReq,
  input  wire logic        wakeIrq,
  input  wire logic        extReset,
  input  wire logic        oscFailPin,
  output logic             lowPowerActive,
  output logic             pllEnable,
  output logic             pllClockSelect,
  output logic             coreClockEnable,
  output logic             systemClockEnable,
  output logic             oscillatorEnable,
  output logic             regulatorEnable,
  output logic             powerSaveReq,
  output logic             counterFreeze,
  output logic             timerClockEnable,
  output logic             watchdogClockEnable,
  output logic             selfClockMode,
  output logic             selfClockWakeIrq,
  output logic             clockMonitorFailReset,
  output logic             resetSeqStart
);
  import lpc_pkg::*;

  // =====================================================================
  // pin synchroniser and register file
  // =====================================================================
  logic       failMeta;
  logic       oscFail;
  logic       wakeMeta;
  logic       wake;
  logic       rstMeta;
  logic       extRst;
  logic [7:0] ctrl;
  logic [7:0] status;
  logic       flag;
  logic       flagSet;
  logic       pllSelClear;
  logic       qcBusy;
  logic       qcDone;
  logic       qcStart;
  logic       qcAbort;
  logic       qcHold;

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      failMeta <= 1'b0;
      oscFail  <= 1'b0;
      wakeMeta <= 1'b0;
      wake     <= 1'b0;
      rstMeta  <= 1'b0;
      extRst   <= 1'b0;
    end else begin
      failMeta <= oscFailPin;
      oscFail  <= failMeta;
      wakeMeta <= wakeIrq;
      wake     <= wakeMeta;
      rstMeta  <= extReset;
      extRst   <= rstMeta;
    end
  end

  // ctrl bits: 0 monitor, 1 self-clock, 2 self-clock irq, 3 pll stop in wait,
  // 4 pseudo-stop, 5 timer run, 6 pll select, 7 watchdog run
  logic monEn;
  logic scEn;
  logic scIrqEn;
  logic pllWait;
  logic pseudo;
  logic timerRun;
  logic wdRun;
  assign monEn    = ctrl[0];
  assign scEn     = ctrl[1];
  assign scIrqEn  = ctrl[2];
  assign pllWait  = ctrl[3];
  assign pseudo   = ctrl[4];
  assign timerRun = ctrl[5];
  assign wdRun    = ctrl[7];
  assign pllClockSelect = ctrl[6];

  lpc_wb_regs u_regs (
    .sys_clk          (sys_clk),
    .rstn             (rstn),
    .wb_cyc_i         (wb_cyc_i),
    .wb_stb_i         (wb_stb_i),
    .wb_we_i          (wb_we_i),
    .wb_adr_i         (wb_adr_i),
    .wb_sel_i         (wb_sel_i),
    .wb_dat_i         (wb_dat_i),
    .wb_dat_o         (wb_dat_o),
    .wb_ack_o         (wb_ack_o),
    .status           (status),
    .flagSet          (flagSet),
    .pllSelClear      (pllSelClear),
    .ctrl             (ctrl),
    .selfClockIrqFlag (flag)
  );

  // =====================================================================
  // entry / exit sequencer
  // =====================================================================
  lpc_state_t state;
  lpc_state_t next_state;
  logic       isStop;
  logic       next_isStop;
  logic       self_clock_mode;
  logic       next_scm;
  logic       clock_monitor_fail_reset;
  logic       next_clock_monitor_fail_reset;
  logic       scWake;
  logic       next_scWake;
  logic       rstSeq;
  logic       next_rstSeq;
  logic       inWait;
  logic       inStop;
  logic       lossEvent;
  logic       exitReq;

  assign inWait    = (state == LPC_LOWPWR) && !isStop;
  assign inStop    = (state == LPC_LOWPWR) && isStop;
  // no monitoring means no loss is ever seen
  assign lossEvent = monEn && oscFail && !self_clock_mode && (state == LPC_LOWPWR) && !(inStop && !pseudo);
  assign exitReq   = wake || extRst;

  always_comb begin
    next_state   = state;
    next_isStop  = isStop;
    next_scm     = self_clock_mode;
    next_clock_monitor_fail_reset = 1'b0;
    next_scWake  = 1'b0;
    next_rstSeq  = 1'b0;
    flagSet      = 1'b0;
    pllSelClear  = 1'b0;
    qcStart      = 1'b0;
    qcAbort      = 1'b0;
    unique case (state)
      LPC_RUN: begin
        if (stopReq || waitReq) begin
          next_isStop = stopReq;
          next_state  = LPC_SEL_OSC;
        end
      end
      LPC_SEL_OSC: begin
        pllSelClear = isStop || pllWait;
        next_state  = LPC_PLL_OFF;
      end
      LPC_PLL_OFF: next_state = LPC_CORE_OFF;
      LPC_CORE_OFF: next_state = LPC_SYS_OFF;
      LPC_SYS_OFF: begin
        next_state = LPC_LOWPWR;
        if (isStop && !pseudo && self_clock_mode) begin
          qcAbort = 1'b1;
        end
      end
      LPC_LOWPWR: begin
        if (lossEvent && !scEn) begin
          next_clock_monitor_fail_reset = 1'b1;
          next_rstSeq  = 1'b1;
          next_state   = LPC_RUN;
        end else if (lossEvent) begin
          next_scm = 1'b1;
          flagSet  = 1'b1;
          qcStart  = 1'b1;
          if (scIrqEn) begin
            next_scWake = 1'b1;
            next_state  = LPC_RUN;
          end
        end else if (exitReq) begin
          next_state  = LPC_RUN;
          next_rstSeq = extRst;
          if (inStop && !pseudo && self_clock_mode) begin
            qcStart = 1'b1;
          end
        end
      end
      default: next_state = LPC_RUN;
    endcase
    if (qcDone) begin
      next_scm = 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      state   <= LPC_RUN;
      isStop  <= 1'b0;
      self_clock_mode     <= 1'b0;
      clock_monitor_fail_reset <= 1'b0;
      scWake  <= 1'b0;
      rstSeq  <= 1'b0;
    end else begin
      state   <= next_state;
      isStop  <= next_isStop;
      self_clock_mode     <= next_scm;
      clock_monitor_fail_reset <= next_clock_monitor_fail_reset;
      scWake  <= next_scWake;
      rstSeq  <= next_rstSeq;
    end
  end

  // full stop freezes the checker; pseudo-stop keeps it going
  assign qcHold = inStop && !pseudo;

  lpc_quality_check #(
    .GOOD_CYCLES (GOOD_CYCLES)
  ) u_qc (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .start   (qcStart),
    .abort   (qcAbort),
    .hold    (qcHold),
    .oscGood (!oscFail),
    .busy    (qcBusy),
    .done    (qcDone)
  );

  // =====================================================================
  // clock and power gating outputs
  // =====================================================================
  logic pllOffPhase;
  logic coreOffPhase;
  logic sysOffPhase;
  logic fullStop;
  assign pllOffPhase  = (state == LPC_CORE_OFF) || (state == LPC_SYS_OFF) || (state == LPC_LOWPWR);
  assign coreOffPhase = (state == LPC_SYS_OFF) || (state == LPC_LOWPWR);
  assign sysOffPhase  = (state == LPC_LOWPWR);
  assign fullStop     = inStop && !pseudo;

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      lowPowerActive        <= 1'b0;
      pllEnable             <= 1'b1;
      coreClockEnable       <= 1'b1;
      systemClockEnable     <= 1'b1;
      oscillatorEnable      <= 1'b1;
      regulatorEnable       <= 1'b1;
      powerSaveReq          <= 1'b0;
      counterFreeze         <= 1'b0;
      timerClockEnable      <= 1'b1;
      watchdogClockEnable   <= 1'b1;
      selfClockMode         <= 1'b0;
      selfClockWakeIrq      <= 1'b0;
      clockMonitorFailReset <= 1'b0;
      resetSeqStart         <= 1'b0;
    end else begin
      lowPowerActive        <= sysOffPhase;
      // self-clock runs on the PLL, so it must stay on whatever the setting
      pllEnable             <= self_clock_mode || !(pllOffPhase && (isStop || pllWait));
      coreClockEnable       <= !coreOffPhase;
      systemClockEnable     <= !sysOffPhase;
      oscillatorEnable      <= !(inStop && !pseudo);
      regulatorEnable       <= !inStop || self_clock_mode;
      powerSaveReq          <= inStop && !self_clock_mode;
      counterFreeze         <= inStop;
      timerClockEnable      <= !inStop || (pseudo && timerRun);
      watchdogClockEnable   <= !inStop || (pseudo && wdRun);
      selfClockMode         <= self_clock_mode;
      selfClockWakeIrq      <= scWake;
      clockMonitorFailReset <= clock_monitor_fail_reset;
      resetSeqStart         <= rstSeq;
    end
  end

  assign status = {3'h0, fullStop, isStop, sysOffPhase, qcBusy, self_clock_mode};

  // =====================================================================
  // checks
  // =====================================================================
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);

  sequence s_loss_sc;
    inWait && monEn && scEn && oscFail && !self_clock_mode;
  endsequence

  property p_no_action_off;
    (inWait && !monEn) |=> !clock_monitor_fail_reset && !scWake;
  endproperty
  a_no_action_off: assert property (p_no_action_off) else $error("action without monitor");
  property p_cm_reset;
    (inWait && monEn && !scEn && oscFail) |=> clock_monitor_fail_reset ##1 clockMonitorFailReset;
  endproperty
  a_cm_reset: assert property (p_cm_reset) else $error("missing monitor reset");
  property p_sc_enter;
    (s_loss_sc ##0 !scIrqEn) |=> self_clock_mode && inWait ##1 selfClockMode && flag;
  endproperty
  a_sc_enter: assert property (p_sc_enter) else $error("self-clock entry wrong");
  property p_reg_wait;
    inWait [*2] |-> regulatorEnable;
  endproperty
  a_reg_wait: assert property (p_reg_wait) else $error("regulator off in wait");
  property p_sc_irq;
    (s_loss_sc ##0 scIrqEn) |=> scWake ##1 selfClockWakeIrq;
  endproperty
  a_sc_irq: assert property (p_sc_irq) else $error("no self-clock wake");
  property p_osc_stop;
    fullStop |=> !oscillatorEnable;
  endproperty
  a_osc_stop: assert property (p_osc_stop) else $error("oscillator on in stop");
  property p_stop_order;
    (state == LPC_RUN && stopReq) |=> ##1 (state == LPC_PLL_OFF) && !pllClockSelect ##3 sysOffPhase;
  endproperty
  a_stop_order: assert property (p_stop_order) else $error("stop entry order wrong");
  property p_pseudo_check;
    (inStop && pseudo && self_clock_mode) |=> pllEnable && regulatorEnable;
  endproperty
  a_pseudo_check: assert property (p_pseudo_check) else $error("pll or regulator off in pseudo-stop");
  property p_timer_run;
    (inStop && pseudo && timerRun) |=> timerClockEnable;
  endproperty
  a_timer_run: assert property (p_timer_run) else $error("timer stopped in pseudo-stop");
endmodule
`default_nettype wire

// [verification/lpc_core_model.sv]
// processor core model: raises wait or stop requests and holds them until taken
`timescale 1ns/100ps
`default_nettype none
module lpc_core_model (
  input  wire logic sys_clk,
  input  wire logic rstn,
  input  wire logic cmdWait,
  input  wire logic cmdStop,
  input  wire logic lowPowerActive,
  output var logic  waitReq,
  output var logic  stopReq
);
  // =========================================
  // request hold
  // held until low power shows, so a late sample in the run state still sees it
  always @(posedge sys_clk) begin
    if (!rstn) begin
      waitReq <= 1'b0;
      stopReq <= 1'b0;
    end else begin
      if (cmdWait) waitReq <= 1'b1; else if (lowPowerActive) waitReq <= 1'b0;
      if (cmdStop) stopReq <= 1'b1; else if (lowPowerActive) stopReq <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// [verification/test_low_power_clock_loss_control.sv]
// self-checking bench for the low-power clock-loss control
`timescale 1ns/100ps
`default_nettype none
module test_low_power_clock_loss_control;
  localparam int GC = 8;
  logic        sys_clk, rstn, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [3:0]  wb_adr_i, wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, q;
  logic        waitReq, stopReq, wakeIrq, extReset, oscFailPin, cmdWait, cmdStop;
  logic        lowPowerActive, pllEnable, pllClockSelect, coreClockEnable, systemClockEnable;
  logic        oscillatorEnable, regulatorEnable, powerSaveReq, counterFreeze, timerClockEnable;
  logic        watchdogClockEnable, selfClockMode, selfClockWakeIrq, clockMonitorFailReset, resetSeqStart;
  logic [7:0]  c, r;
  int          failures, checked, cmrCount, n;
  // =========================================
  // instances
  lpc_ctrl #(.GOOD_CYCLES(13'h0008)) dut_u (.sys_clk, .rstn, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .waitReq, .stopReq, .wakeIrq, .extReset, .oscFailPin,
    .lowPowerActive, .pllEnable, .pllClockSelect, .coreClockEnable, .systemClockEnable, .oscillatorEnable,
    .regulatorEnable, .powerSaveReq, .counterFreeze, .timerClockEnable, .watchdogClockEnable,
    .selfClockMode, .selfClockWakeIrq, .clockMonitorFailReset, .resetSeqStart);
  lpc_core_model core_u (.sys_clk, .rstn, .cmdWait, .cmdStop, .lowPowerActive, .waitReq, .stopReq);
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) if (clockMonitorFailReset === 1'b1) cmrCount++;
  // =========================================
  // helpers
  task automatic summarize;
    $display("checked=%0d failures=%0d", checked, failures);
    if (failures == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic sig(input int i);
    case (i)
      0: return lowPowerActive;
      1: return selfClockMode;
      2: return pllEnable;
      3: return clockMonitorFailReset;
      4: return selfClockWakeIrq;
      default: return resetSeqStart;
    endcase
  endfunction
  // bounded wait; pulses stand one cycle and are caught at every edge
  task automatic waitFor(input int i, input logic v, input int lim, output int k);
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
    end while (sig(i) !== v && k < lim);
    if (sig(i) !== v) begin
      failures++;
      $display("[ERR] %0t wait ran out on signal %0d", $time, i);
      summarize();
    end
  endtask
  task automatic wbXfer(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] rd);
    int k;
    k = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge sys_clk);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 50);
    if (wb_ack_o !== 1'b1) begin
      failures++;
      $display("[ERR] %0t bus answer missing", $time);
      summarize();
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic enter(input bit stp, input logic [7:0] cv);
    int k;
    wbXfer(1'b1, 4'h0, {24'h0, cv}, q);
    if (stp) cmdStop <= 1'b1; else cmdWait <= 1'b1;
    @(posedge sys_clk);
    cmdStop <= 1'b0;
    cmdWait <= 1'b0;
    if ((stp || cv[3]) && selfClockMode !== 1'b1) begin
      waitFor(2, 1'b0, 20, k);
      chk(32'(coreClockEnable), 32'h1);
    end
    waitFor(0, 1'b1, 20, k);
    if (stp || cv[3]) chk(32'(pllClockSelect), 32'h0);
  endtask
  task automatic wake;
    wakeIrq <= 1'b1;
    repeat (3) @(posedge sys_clk);
    wakeIrq <= 1'b0;
  endtask
  // =========================================
  // main sequence
  initial begin
    {rstn, wb_cyc_i, wb_stb_i, wb_we_i, wakeIrq, extReset, oscFailPin, cmdWait, cmdStop} = '0;
    wb_adr_i = 4'h0;
    wb_sel_i = 4'hf;
    wb_dat_i = 32'h0;
    failures = 0;
    checked = 0;
    cmrCount = 0;
    repeat (20) @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
    void'($urandom(32'hc7e1));
    wbXfer(1'b0, 4'h0, 32'h0, q);
    chk(q, 32'h2);
    wbXfer(1'b0, 4'h8, 32'h0, q);
    chk(q, 32'h0);
    // low lane not selected: the write must be dropped
    wb_sel_i <= 4'he;
    wbXfer(1'b1, 4'h0, 32'hff, q);
    wb_sel_i <= 4'hf;
    wbXfer(1'b0, 4'h0, 32'h0, q);
    chk(q, 32'h2);
    enter(1'b0, 8'h00);
    oscFailPin <= 1'b1;
    repeat (10) @(posedge sys_clk);
    oscFailPin <= 1'b0;
    repeat (4) @(posedge sys_clk);
    chk(32'(lowPowerActive), 32'h1);
    chk(32'(cmrCount), 32'h0);
    wake();
    waitFor(0, 1'b0, 20, n);
    enter(1'b0, 8'h01);
    oscFailPin <= 1'b1;
    waitFor(3, 1'b1, 20, n);
    oscFailPin <= 1'b0;
    waitFor(0, 1'b0, 5, n);
    enter(1'b0, 8'h4b);
    oscFailPin <= 1'b1;
    waitFor(1, 1'b1, 20, n);
    repeat (40) @(posedge sys_clk);
    chk(32'(selfClockMode), 32'h1);
    chk({lowPowerActive, regulatorEnable, pllEnable}, 32'h7);
    wbXfer(1'b0, 4'h4, 32'h0, q);
    chk(32'(q[0]), 32'h1);
    oscFailPin <= 1'b0;
    waitFor(1, 1'b0, GC + 12, n);
    chk(32'(n >= GC && n <= GC + 8), 32'h1);
    chk({lowPowerActive, regulatorEnable, pllEnable}, 32'h6);
    extReset <= 1'b1;
    waitFor(5, 1'b1, 20, n);
    extReset <= 1'b0;
    chk(32'(selfClockMode), 32'h0);
    enter(1'b0, 8'h03);
    oscFailPin <= 1'b1;
    waitFor(1, 1'b1, 20, n);
    wake();
    waitFor(0, 1'b0, 20, n);
    chk({selfClockMode, pllEnable}, 32'h3);
    enter(1'b1, 8'h03);
    oscFailPin <= 1'b0;
    repeat (GC + 12) @(posedge sys_clk);
    chk({selfClockMode, counterFreeze}, 32'h3);
    wakeIrq <= 1'b1;
    waitFor(1, 1'b0, GC + 24, n);
    wakeIrq <= 1'b0;
    chk(32'(n > GC), 32'h1);
    wbXfer(1'b0, 4'h4, 32'h0, q);
    chk(32'(q[0]), 32'h1);
    wbXfer(1'b1, 4'h4, 32'h1, q);
    wbXfer(1'b0, 4'h4, 32'h0, q);
    chk(32'(q[0]), 32'h0);
    enter(1'b0, 8'h07);
    oscFailPin <= 1'b1;
    waitFor(4, 1'b1, 20, n);
    waitFor(0, 1'b0, 5, n);
    chk(32'(selfClockMode), 32'h1);
    // pseudo-stop entered with the clock still lost: checking must go on there
    enter(1'b1, 8'h13);
    chk({pllEnable, regulatorEnable, selfClockMode, powerSaveReq}, 32'he);
    oscFailPin <= 1'b0;
    waitFor(1, 1'b0, GC + 12, n);
    chk({lowPowerActive, pllEnable, powerSaveReq}, 32'h5);
    wake();
    waitFor(0, 1'b0, 20, n);
    for (int k = 0; k < 4; k++) begin
      r = 8'($urandom);
      c = {r[7], 1'b1, r[5] | k[1], k[0], 4'h1};
      enter(1'b1, c);
      chk({coreClockEnable, systemClockEnable, pllEnable}, 32'h0);
      chk(32'(oscillatorEnable), 32'(c[4]));
      chk({timerClockEnable, watchdogClockEnable}, {c[4] & c[5], c[4] & c[7]});
      chk({powerSaveReq, counterFreeze}, 32'h3);
      wake();
      waitFor(0, 1'b0, 20, n);
    end
    summarize();
  end
endmodule
`default_nettype wire
